// ===== include/pic_pkg.sv
// Shared constants, register map, configuration carrier and helpers for the
// process controller. Assumes a single 10 MHz clock domain.
package pic_pkg;

	// Clock rate and the fixed sampling interval
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned SAMPLE_MS = 500;
	localparam int unsigned SAMPLE_CYCLES = CLK_HZ / 1000 * SAMPLE_MS;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SETPOINT = 8'h04;
	localparam logic [7:0] OFS_PGAIN = 8'h08;
	localparam logic [7:0] OFS_RPERIOD = 8'h0c;
	localparam logic [7:0] OFS_MANUAL = 8'h10;
	localparam logic [7:0] OFS_PV_MIN = 8'h14;
	localparam logic [7:0] OFS_PV_MAX = 8'h18;
	localparam logic [7:0] OFS_SC_GAIN = 8'h1c;
	localparam logic [7:0] OFS_SC_OFFSET = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_PV_UPD = 8'h28;
	localparam logic [7:0] OFS_INTEGRAL = 8'h2c;
	localparam logic [7:0] OFS_SAMPLES = 8'h30;

	// Field positions
	localparam int CTRL_SENSE_BIT = 0;
	localparam int ST_MODE_LSB = 16;
	localparam int ST_AT_SP_BIT = 18;
	localparam int ST_AT_MAX_BIT = 19;
	localparam int ST_AT_MIN_BIT = 20;

	// Legal ranges (gains in hundredths, reset period in seconds)
	localparam int SP_LO = -10000;
	localparam int SP_HI = 20000;
	localparam int PGAIN_HI = 9999;
	localparam int RPERIOD_LO = 1;
	localparam int RPERIOD_OFF = 5999;
	localparam int AQ_HI = 1000;
	localparam int SC_GAIN_LO = -1000;
	localparam int SC_GAIN_HI = 1000;
	localparam int SC_OFF_LO = -10000;
	localparam int SC_OFF_HI = 10000;

	// Reset values
	localparam logic RST_SENSE = 1'b1;
	localparam int RST_SETPOINT = 0;
	localparam int RST_PGAIN = 100;
	localparam int RST_RPERIOD = 60;
	localparam int RST_MANUAL = 0;
	localparam int RST_SC_GAIN = 100;
	localparam int RST_SC_OFFSET = 0;

	// Fixed point: gains carry two decimals, integral sixteen fraction bits
	localparam int GAIN_DIV = 100;
	localparam int FRAC = 16;
	localparam int I_SCALE = GAIN_DIV * 1000 / SAMPLE_MS;

	// AXI4-Lite responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {MODE_RESET, MODE_MANUAL, MODE_AUTO} pic_mode_t;

	// Configuration carried from register file to datapath
	typedef struct packed {
		logic sense_pos;
		logic signed [15:0] setpoint;
		logic [13:0] pgain;
		logic [12:0] rperiod;
		logic [10:0] manual;
		logic signed [15:0] pv_min;
		logic signed [15:0] pv_max;
		logic signed [15:0] sc_gain;
		logic signed [15:0] sc_offset;
	} pic_cfg_t;

	// Saturate a wide signed value into [lo, hi]
	function automatic logic signed [47:0] pic_sat(logic signed [47:0] v, int lo, int hi);
		logic signed [47:0] l;
		logic signed [47:0] h;
		l = 48'(lo);
		h = 48'(hi);
		if (v > h)
			return h;
		if (v < l)
			return l;
		return v;
	endfunction

	// Byte-lane merge of a write into the old register image
	function automatic logic [31:0] pic_merge(logic [31:0] old, logic [31:0] nv, logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				r[i*8 +: 8] = nv[i*8 +: 8];
		end
		return r;
	endfunction

endpackage

// ===== src/pic_tick.sv
// Free-running sample timer: one-cycle pulse every CYCLES clocks.
// Assumes the system clock and synchronous active-low reset.
module pic_tick
	import pic_pkg::*;
#(
	parameter int unsigned CYCLES = SAMPLE_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Sample strobe
	output logic tick
);

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;

	// Wrap at the end of each interval
	always_comb begin
		tick = (cnt_q == 32'(CYCLES - 1));
		cnt_d = tick ? 32'h0 : cnt_q + 32'h1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			cnt_q <= 32'h0;
		else
			cnt_q <= cnt_d;
	end

endmodule

// ===== src/pic_scale.sv
// Process value conditioning: gain, offset, then clamp to the limits.
// Purely combinational; the caller registers what it needs.
module pic_scale
	import pic_pkg::*;
(
	// Configuration and raw sample
	input wire pic_cfg_t cfg,
	input wire logic signed [15:0] raw,
	// Conditioned value
	output logic signed [15:0] pv_upd
);

	logic signed [47:0] scaled;
	logic signed [47:0] clamped;

	// Scale then clamp; maximum is checked first
	always_comb begin
		scaled = 48'(raw) * 48'(cfg.sc_gain) / 48'(GAIN_DIV) + 48'(cfg.sc_offset);
		clamped = scaled;
		if (scaled > 48'(cfg.pv_max))
			clamped = 48'(cfg.pv_max);
		else if (scaled < 48'(cfg.pv_min))
			clamped = 48'(cfg.pv_min);
		pv_upd = clamped[15:0];
	end

endmodule

// ===== src/pic_controller.sv
// Proportional-integral process controller with an AXI4-Lite register file.
// Assumes one clock, synchronous reset, and mode/reset inputs synchronous to it.
module pic_controller
	import pic_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Process side
	input wire logic auto_manual_select,
	input wire logic output_reset,
	input wire logic signed [15:0] process_value,
	output logic [10:0] analog_output
);

	// Bus state
	logic aw_have_q, aw_have_d;
	logic w_have_q, w_have_d;
	logic [7:0] waddr_q, waddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic wr_fire;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_img;

	// Configuration state
	pic_cfg_t cfg_q, cfg_d;

	// Control state
	pic_mode_t mode_q, mode_d;
	logic signed [31:0] integ_q, integ_d;
	logic [10:0] aq_q, aq_d;
	logic signed [15:0] pv_q, pv_d;
	logic [31:0] samples_q, samples_d;

	// Datapath
	logic tick;
	logic signed [15:0] pv_upd;
	logic signed [17:0] err;
	logic signed [47:0] prod;
	logic signed [47:0] p_term;
	logic signed [47:0] i_inc;
	logic signed [47:0] integ_new;
	logic signed [47:0] out_new;

	// Sampling interval timer
	pic_tick #(
		.CYCLES(SAMPLE_CYCLES_P)
	) u_tick (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick)
	);

	// Process value conditioning
	pic_scale u_scale (
		.cfg(cfg_q),
		.raw(process_value),
		.pv_upd(pv_upd)
	);

	// Bus handshakes and outputs
	assign awready = !aw_have_q;
	assign wready = !w_have_q;
	assign arready = !rvalid_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign analog_output = aq_q;

	// Write performed once both address and data are held
	assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

	// Address decode for writes, read-only words included
	always_comb begin
		unique case (waddr_q)
			OFS_CTRL, OFS_SETPOINT, OFS_PGAIN, OFS_RPERIOD, OFS_MANUAL,
			OFS_PV_MIN, OFS_PV_MAX, OFS_SC_GAIN, OFS_SC_OFFSET,
			OFS_STATUS, OFS_PV_UPD, OFS_INTEGRAL, OFS_SAMPLES:
				wr_hit = 1'b1;
			default:
				wr_hit = 1'b0;
		endcase
	end

	// Read image of the addressed word
	always_comb begin
		rd_img = 32'h0;
		rd_hit = 1'b1;
		unique case (araddr)
			OFS_CTRL: rd_img[CTRL_SENSE_BIT] = cfg_q.sense_pos;
			OFS_SETPOINT: rd_img = 32'(cfg_q.setpoint);
			OFS_PGAIN: rd_img = 32'(cfg_q.pgain);
			OFS_RPERIOD: rd_img = 32'(cfg_q.rperiod);
			OFS_MANUAL: rd_img = 32'(cfg_q.manual);
			OFS_PV_MIN: rd_img = 32'(cfg_q.pv_min);
			OFS_PV_MAX: rd_img = 32'(cfg_q.pv_max);
			OFS_SC_GAIN: rd_img = 32'(cfg_q.sc_gain);
			OFS_SC_OFFSET: rd_img = 32'(cfg_q.sc_offset);
			OFS_STATUS: begin
				rd_img[10:0] = aq_q;
				rd_img[ST_MODE_LSB +: 2] = mode_q;
				rd_img[ST_AT_SP_BIT] = (pv_q == cfg_q.setpoint);
				rd_img[ST_AT_MAX_BIT] = (aq_q == 11'(AQ_HI));
				rd_img[ST_AT_MIN_BIT] = (aq_q == 11'h0);
			end
			OFS_PV_UPD: rd_img = 32'(pv_q);
			OFS_INTEGRAL: rd_img = 32'(integ_q >>> FRAC);
			OFS_SAMPLES: rd_img = samples_q;
			default: rd_hit = 1'b0;
		endcase
	end

	// Bus channel next state
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (awvalid && awready) begin
			aw_have_d = 1'b1;
			waddr_d = awaddr;
		end
		if (wvalid && wready) begin
			w_have_d = 1'b1;
			wdata_d = wdata;
			wstrb_d = wstrb;
		end
		if (bvalid_q && bready)
			bvalid_d = 1'b0;
		if (wr_fire) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wr_hit ? RESP_OKAY : RESP_DECERR;
		end
		if (rvalid_q && rready)
			rvalid_d = 1'b0;
		if (arvalid && arready) begin
			rvalid_d = 1'b1;
			rdata_d = rd_img;
			rresp_d = rd_hit ? RESP_OKAY : RESP_DECERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			waddr_q <= 8'h0;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end else begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// Merge a write into a field and saturate it to its legal range
	function automatic logic signed [47:0] wr_val(logic [31:0] old, int lo, int hi);
		logic [31:0] m;
		m = pic_merge(old, wdata_q, wstrb_q);
		return pic_sat(48'(signed'(m)), lo, hi);
	endfunction

	// Configuration writes; out-of-range values are pinned to the limit
	always_comb begin
		cfg_d = cfg_q;
		if (wr_fire) begin
			unique case (waddr_q)
				OFS_CTRL: if (wstrb_q[CTRL_SENSE_BIT / 8]) cfg_d.sense_pos = wdata_q[CTRL_SENSE_BIT];
				OFS_SETPOINT: cfg_d.setpoint = 16'(wr_val(32'(cfg_q.setpoint), SP_LO, SP_HI));
				OFS_PGAIN: cfg_d.pgain = 14'(wr_val(32'(cfg_q.pgain), 0, PGAIN_HI));
				OFS_RPERIOD: cfg_d.rperiod = 13'(wr_val(32'(cfg_q.rperiod), RPERIOD_LO, RPERIOD_OFF));
				OFS_MANUAL: cfg_d.manual = 11'(wr_val(32'(cfg_q.manual), 0, AQ_HI));
				OFS_PV_MIN: cfg_d.pv_min = 16'(wr_val(32'(cfg_q.pv_min), SP_LO, SP_HI));
				OFS_PV_MAX: cfg_d.pv_max = 16'(wr_val(32'(cfg_q.pv_max), SP_LO, SP_HI));
				OFS_SC_GAIN: cfg_d.sc_gain = 16'(wr_val(32'(cfg_q.sc_gain), SC_GAIN_LO, SC_GAIN_HI));
				OFS_SC_OFFSET: cfg_d.sc_offset = 16'(wr_val(32'(cfg_q.sc_offset), SC_OFF_LO, SC_OFF_HI));
				default: cfg_d = cfg_q;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q.sense_pos <= RST_SENSE;
			cfg_q.setpoint <= 16'(RST_SETPOINT);
			cfg_q.pgain <= 14'(RST_PGAIN);
			cfg_q.rperiod <= 13'(RST_RPERIOD);
			cfg_q.manual <= 11'(RST_MANUAL);
			cfg_q.pv_min <= 16'(SP_LO);
			cfg_q.pv_max <= 16'(SP_HI);
			cfg_q.sc_gain <= 16'(RST_SC_GAIN);
			cfg_q.sc_offset <= 16'(RST_SC_OFFSET);
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// Error, proportional and integral terms for one sample
	always_comb begin
		if (cfg_q.sense_pos)
			err = 18'(cfg_q.setpoint) - 18'(pv_upd);
		else
			err = 18'(pv_upd) - 18'(cfg_q.setpoint);
		prod = 48'(err) * 48'(signed'({1'b0, cfg_q.pgain}));
		if (cfg_q.pgain == 14'h0)
			p_term = 48'sh0;
		else
			p_term = prod / 48'(GAIN_DIV);
		if (cfg_q.rperiod == 13'(RPERIOD_OFF))
			i_inc = 48'sh0;
		else
			i_inc = (prod <<< FRAC) / (48'(signed'({1'b0, cfg_q.rperiod})) * 48'(I_SCALE));
		integ_new = pic_sat(48'(integ_q) + i_inc, 0, AQ_HI <<< FRAC);
		out_new = pic_sat((integ_new >>> FRAC) + p_term, 0, AQ_HI);
	end

	// Mode selection and periodic output update
	always_comb begin
		mode_d = mode_q;
		integ_d = integ_q;
		aq_d = aq_q;
		pv_d = pv_q;
		samples_d = samples_q;
		if (tick)
			pv_d = pv_upd;
		if (output_reset) begin
			mode_d = MODE_RESET;
			integ_d = 32'sh0;
			aq_d = 11'h0;
		end else if (!auto_manual_select) begin
			mode_d = MODE_MANUAL;
			aq_d = cfg_q.manual;
		end else if (mode_q != MODE_AUTO) begin
			mode_d = MODE_AUTO;
			integ_d = 32'(cfg_q.manual) <<< FRAC;
			aq_d = cfg_q.manual;
		end else if (tick) begin
			samples_d = samples_q + 32'h1;
			if (err != 18'sh0) begin
				integ_d = 32'(integ_new);
				aq_d = 11'(out_new);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= MODE_RESET;
			integ_q <= 32'sh0;
			aq_q <= 11'h0;
			pv_q <= 16'sh0;
			samples_q <= 32'h0;
		end else begin
			mode_q <= mode_d;
			integ_q <= integ_d;
			aq_q <= aq_d;
			pv_q <= pv_d;
			samples_q <= samples_d;
		end
	end

endmodule

// ===== verification/pic_plant.sv
// Partner model: analog source that feeds the raw process value.
// Assumes the bench sets the wanted value; it reaches the block one clock later.
module pic_plant (
	// Clock
	input wire logic aclk,
	// Wanted raw value
	input wire logic signed [15:0] pv_target,
	// Raw value into the block
	output logic signed [15:0] process_value
);
	timeunit 1ns;
	timeprecision 1ns;
	// Defined level from time zero
	initial process_value = 16'h0000;
	// Transducer lag of one clock
	always @(posedge aclk)
		process_value <= pv_target;
endmodule

// ===== verification/pic_controller_asserts.sv
// Checker for the controller top: output range, reset, modes, sample timing, bus.
// Assumes one clock domain; bound to every controller instance below.
module pic_chk
	import pic_pkg::*;
#(
	parameter int unsigned SAMPLE_CYCLES_P = 20
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	// Process side
	input wire logic auto_manual_select,
	input wire logic output_reset,
	input wire logic [10:0] analog_output
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic steady;
	logic tchg;
	logic [1:0] st_q, st_d;
	logic [10:0] out_q;
	int gap_q, gap_d;
	logic have_q, have_d;
	// Output moves in steady automatic running, entry step excluded
	assign steady = auto_manual_select && !output_reset;
	assign tchg = (analog_output != out_q) && steady && (st_q == 2'h3);
	// Cycles since the last sample-driven change
	always_comb begin
		st_d = {st_q[0], steady};
		gap_d = tchg ? 1 : gap_q + 1;
		have_d = have_q || tchg;
		if (!steady) begin
			gap_d = 0;
			have_d = 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= 2'h0;
			gap_q <= 0;
			have_q <= 1'b0;
			out_q <= 11'h000;
		end else begin
			st_q <= st_d;
			gap_q <= gap_d;
			have_q <= have_d;
			out_q <= analog_output;
		end
	end
	sequence man_settled_s;
		(!output_reset && !auto_manual_select && !wvalid)[*4];
	endsequence
	sequence auto_entry_s;
		man_settled_s ##1 (auto_manual_select && !output_reset && !wvalid);
	endsequence
	sequence rst_pair_s;
		output_reset ##1 output_reset;
	endsequence
	sequence wr_taken_s;
		awvalid && awready && wvalid && wready && !bvalid;
	endsequence
	out_range_a: assert property (analog_output <= 11'h3e8)
		else $error("output above full scale");
	reset_zero_a: assert property (output_reset |=> analog_output == 11'h000)
		else $error("output not zero under reset input");
	reset_hold_a: assert property (rst_pair_s |=> $stable(analog_output))
		else $error("output moved under held reset input");
	manual_hold_a: assert property (man_settled_s |-> $stable(analog_output))
		else $error("manual output moved without a write");
	auto_entry_a: assert property (auto_entry_s |=> analog_output == $past(analog_output))
		else $error("entry to automatic did not start from manual value");
	tick_gap_a: assert property (tchg && have_q |-> (gap_q % SAMPLE_CYCLES_P) == 0)
		else $error("output update off the sample grid");
	b_answer_a: assert property (wr_taken_s |-> ##2 bvalid)
		else $error("write response late");
	r_block_a: assert property (rvalid && !rready |=> rvalid && !arready)
		else $error("read data dropped or address taken while data pending");
endmodule

bind pic_controller pic_chk #(.SAMPLE_CYCLES_P(SAMPLE_CYCLES_P)) u_chk (.aclk, .aresetn, .awvalid, .awready,
	.wvalid, .wready, .bvalid, .arready, .rvalid, .rready, .auto_manual_select, .output_reset, .analog_output);

// ===== verification/tb_top.sv
// Self-checking bench: registers, modes, control direction, terms and scaling.
// Assumes the bound checker and a 20-cycle sample period.
module tb_top
	import pic_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SP = 20;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, auto_manual_select, output_reset;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic signed [15:0] pv_target, process_value;
	logic [10:0] analog_output;
	int n_fail, n_compared;

	pic_controller #(.SAMPLE_CYCLES_P(SP)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .auto_manual_select, .output_reset, .process_value, .analog_output);
	pic_plant plant (.aclk, .pv_target, .process_value);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task automatic check(string w, logic [31:0] s, logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", w, e, s);
		end
	endtask

	// One write; address and data offered together, each released when taken
	task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		check("bresp", {30'h0, bresp}, {30'h0, er});
	endtask

	task automatic axi_rd(logic [7:0] a, logic [31:0] e, logic [1:0] er, string w);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		check(w, rdata, e);
		check("rresp", {30'h0, rresp}, {30'h0, er});
	endtask

	// Edges until the output changes; the watchdog bounds a hang
	task automatic wait_out(output int c);
		logic [10:0] o;
		o = analog_output;
		c = 0;
		while (analog_output === o) begin
			@(posedge aclk);
			c++;
		end
	endtask

	task automatic to_manual();
		auto_manual_select <= 1'b0;
		pv_target <= 16'h0000;
		repeat (3) @(posedge aclk);
	endtask

	task automatic t_regs();
		axi_rd(OFS_CTRL, 32'h1, RESP_OKAY, "sense");
		axi_rd(OFS_PGAIN, 32'h64, RESP_OKAY, "pgain");
		axi_rd(OFS_PV_MIN, 32'hffffd8f0, RESP_OKAY, "pv_min");
		axi_rd(8'h40, 32'h0, RESP_DECERR, "unmapped");
		axi_wr(8'h40, 32'h5, RESP_DECERR);
		axi_wr(OFS_SETPOINT, 32'h7530, RESP_OKAY);
		axi_rd(OFS_SETPOINT, 32'h4e20, RESP_OKAY, "sp_hi");
		axi_wr(OFS_SETPOINT, 32'hffffb1e0, RESP_OKAY);
		axi_rd(OFS_SETPOINT, 32'hffffd8f0, RESP_OKAY, "sp_lo");
		axi_wr(OFS_SETPOINT, 32'h0, RESP_OKAY);
		$display("test regs done");
	endtask

	task automatic t_manual();
		axi_wr(OFS_MANUAL, 32'h1f4, RESP_OKAY);
		repeat (3) @(posedge aclk);
		check("manual", analog_output, 32'h1f4);
		axi_wr(OFS_MANUAL, 32'h7d0, RESP_OKAY);
		repeat (3) @(posedge aclk);
		check("manual_sat", analog_output, 32'h3e8);
		axi_rd(OFS_STATUS, 32'h000d03e8, RESP_OKAY, "status");
		output_reset <= 1'b1;
		auto_manual_select <= 1'b1;
		repeat (3) @(posedge aclk);
		check("rst_auto", analog_output, 32'h0);
		auto_manual_select <= 1'b0;
		repeat (3) @(posedge aclk);
		check("rst_man", analog_output, 32'h0);
		output_reset <= 1'b0;
		$display("test manual done");
	endtask

	task automatic t_auto();
		int c;
		axi_wr(OFS_MANUAL, 32'h12c, RESP_OKAY);
		repeat (3) @(posedge aclk);
		auto_manual_select <= 1'b1;
		repeat (2) @(posedge aclk);
		check("entry", analog_output, 32'h12c);
		repeat (25) @(posedge aclk);
		check("at_sp", analog_output, 32'h12c);
		pv_target <= 16'hff9c;
		wait_out(c);
		check("rise", analog_output, 32'h190);
		wait_out(c);
		check("keep", analog_output, 32'h191);
		check("period", 32'(c), 32'(SP));
		$display("test auto done");
	endtask

	task automatic t_neg();
		int c;
		to_manual();
		axi_wr(OFS_CTRL, 32'h0, RESP_OKAY); // sense changed only while manual
		auto_manual_select <= 1'b1;
		repeat (3) @(posedge aclk);
		pv_target <= 16'hff9c;
		wait_out(c);
		check("fall", analog_output, 32'hc7);
		to_manual();
		axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
		$display("test negative done");
	endtask

	task automatic t_terms();
		logic [31:0] kp[2] = '{32'h0, 32'h64};
		logic [31:0] ti[2] = '{32'h3c, 32'h176f};
		logic [31:0] ex[2] = '{32'h12c, 32'h190};
		for (int i = 0; i < 2; i++) begin
			to_manual();
			axi_wr(OFS_PGAIN, kp[i], RESP_OKAY);
			axi_wr(OFS_RPERIOD, ti[i], RESP_OKAY);
			auto_manual_select <= 1'b1;
			repeat (3) @(posedge aclk);
			pv_target <= 16'hff9c;
			repeat (25) @(posedge aclk);
			check("term", analog_output, ex[i]);
			repeat (SP) @(posedge aclk);
			check("term_hold", analog_output, ex[i]);
		end
		$display("test terms done");
	endtask

	task automatic t_scale();
		axi_wr(OFS_SC_GAIN, 32'hffffff38, RESP_OKAY);
		axi_wr(OFS_SC_OFFSET, 32'h32, RESP_OKAY);
		pv_target <= 16'h0064;
		repeat (25) @(posedge aclk);
		axi_rd(OFS_PV_UPD, 32'hffffff6a, RESP_OKAY, "scaled");
		axi_wr(OFS_SC_GAIN, 32'h64, RESP_OKAY);
		axi_wr(OFS_SC_OFFSET, 32'h0, RESP_OKAY);
		axi_wr(OFS_PV_MAX, 32'h3e8, RESP_OKAY);
		pv_target <= 16'h0bb8;
		repeat (25) @(posedge aclk);
		axi_rd(OFS_PV_UPD, 32'h3e8, RESP_OKAY, "clamp_hi");
		check("floor", analog_output, 32'h0);
		axi_wr(OFS_PV_MIN, 32'hfffffe0c, RESP_OKAY);
		axi_wr(OFS_PGAIN, 32'h270f, RESP_OKAY);
		pv_target <= 16'hf448;
		repeat (25) @(posedge aclk);
		axi_rd(OFS_PV_UPD, 32'hfffffe0c, RESP_OKAY, "clamp_lo");
		check("ceiling", analog_output, 32'h3e8);
		$display("test scale done");
	endtask

	task automatic final_report();
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence after five reset cycles
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, auto_manual_select, output_reset} = 8'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hf;
		pv_target = 16'h0000;
		n_fail = 0;
		n_compared = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_manual();
		t_auto();
		t_neg();
		t_terms();
		t_scale();
		final_report();
	end

	// Watchdog: the tests need well under a thousand cycles
	initial begin
		repeat (3000) @(posedge aclk);
		n_fail++;
		final_report();
	end
endmodule
